// *** logic/gdrp_dev.sv ***
// slave end: read path of the dual-bank gamma dac register file
`timescale 1ns/100ps
`include "gdrp_consts.svh"

// Summary of operation
// R1: master nacks final byte to end read
// R2: master sends address with write direction first
// R3: slave acks own address with write direction
// R4: pointer byte follows and slave acks it
// R5: readdress with read direction, slave acks
// R6: stream registers from pointer, auto incrementing
// R7: master acks every byte but the last
// R8: master nacks last byte, then stops
// R9: pointer walks 28 slots, 24 real registers
// R10: slots 12 to 15 are nacked, bank two follows
// R11: stop, start or master nack ends session
// R12: ten-bit code in two bytes, high first
// R13: first bank channel one at pointer zero
// R14: high byte: mode bit, zeros, code bits 9..8
module gdrp_dev (
	input  wire logic               sys_clk,
	input  wire logic               srst,
	gdrp_if.dev                     bus,
	input  wire logic               ld_en,
	input  wire gdrp_pkg::gdrp_idx_t  ld_idx,
	input  wire logic               ld_mode,
	input  wire gdrp_pkg::gdrp_code_t ld_code,
	output gdrp_pkg::gdrp_byte_t    ptr,
	output logic                    active,
	output logic                    byte_sent
);
	import gdrp_pkg::*;

	logic [2:0]  scl_sync_q;
	logic [2:0]  sda_sync_q;
	gdrp_dst_t   st_q;
	gdrp_dst_t   ret_q;
	logic [3:0]  cnt_q;
	gdrp_byte_t  sh_q;
	gdrp_byte_t  ptr_q;
	logic        hi_q;
	logic        oe_q;
	logic        sent_q;
	gdrp_word_t  mem_q [`GDRP_NREG];

	wire         scl_s;
	wire         scl_p;
	wire         sda_s;
	wire         sda_p;
	wire         scl_rise;
	wire         scl_fall;
	wire         start_ev;
	wire         stop_ev;
	wire         byte_done;
	wire         addr_hit;
	wire         bank1;
	wire         ptr_valid;
	gdrp_idx_t   mem_idx;
	gdrp_word_t  cur_word;
	gdrp_byte_t  tx_byte;
	gdrp_byte_t  ptr_next;

	// bit 0 of each chain is the metastable stage, read only by bit 1
	assign scl_s = scl_sync_q[1];
	assign scl_p = scl_sync_q[2];
	assign sda_s = sda_sync_q[1];
	assign sda_p = sda_sync_q[2];

	assign scl_rise  = scl_s & ~scl_p;
	assign scl_fall  = ~scl_s & scl_p;
	// sda moving while scl stays high marks a bus condition
	assign start_ev  = scl_s & scl_p & sda_p & ~sda_s; // R11
	assign stop_ev   = scl_s & scl_p & ~sda_p & sda_s; // R11
	assign byte_done = cnt_q == `GDRP_BYTE_BITS;
	assign addr_hit  = sh_q[7:1] == `GDRP_ADDR;

	// bank one from pointer zero, then a four-slot hole, then bank two
	assign bank1     = ptr_q < `GDRP_BANK_LEN; // R13
	assign ptr_valid = bank1 | (ptr_q >= `GDRP_BANK2 && ptr_q <= `GDRP_PTR_LAST); // R10
	assign mem_idx   = bank1 ? ptr_q[4:0] : 5'(ptr_q - `GDRP_HOLE_LEN);
	// hole slots read back as zero rather than a stale register
	assign cur_word  = ptr_valid ? mem_q[mem_idx] : '0;
	assign tx_byte   = hi_q ? {cur_word[`GDRP_MODE_BIT], 5'h00, cur_word[9:8]} // R14
	                        : cur_word[7:0]; // R12
	assign ptr_next  = (ptr_q >= `GDRP_PTR_LAST) ? 8'h00 : ptr_q + 8'h01; // R9

	assign bus.dev_sda_o  = 1'h0;
	assign bus.dev_sda_oe = oe_q;
	assign ptr            = ptr_q;
	assign active         = st_q != D_IDLE;
	assign byte_sent      = sent_q;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
		end else begin
			scl_sync_q <= {scl_sync_q[1:0], bus.scl};
			sda_sync_q <= {sda_sync_q[1:0], bus.sda};
		end
	end

	// register contents are loaded by the write path on the user side
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < `GDRP_NREG; i++) begin
				mem_q[i] <= '0;
			end
		end else if (ld_en && ld_idx < `GDRP_NREG) begin
			mem_q[ld_idx] <= {ld_mode, ld_code};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q   <= D_IDLE;
			ret_q  <= D_IDLE;
			cnt_q  <= 4'h0;
			sh_q   <= 8'h00;
			ptr_q  <= 8'h00;
			hi_q   <= 1'h1;
			oe_q   <= 1'h0;
			sent_q <= 1'h0;
		end else begin
			sent_q <= 1'h0;
			if (stop_ev) begin
				st_q <= D_IDLE; // R11
				oe_q <= 1'h0;
			end else if (start_ev) begin
				st_q  <= D_ADDR; // R11
				cnt_q <= 4'h0;
				oe_q  <= 1'h0;
			end else begin
				unique case (st_q)
				D_IDLE: begin
				end
				D_ADDR, D_PTR, D_WDAT: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && byte_done) begin
						st_q <= D_ACK;
						hi_q <= 1'h1;
						oe_q <= 1'h1;
						if (st_q == D_ADDR) begin
							// foreign address: stay off the bus until the next start
							if (!addr_hit) begin
								st_q <= D_IDLE;
								oe_q <= 1'h0;
							end
							ret_q <= (sh_q[0] == `GDRP_DIR_RD) ? D_TX : D_PTR; // R3 R5
						end else if (st_q == D_PTR) begin
							ptr_q <= sh_q; // R4
							ret_q <= D_WDAT;
						end else begin
							// data is not stored here; only the ack pattern and the pointer walk are kept
							oe_q <= ptr_valid; // R10
							hi_q <= ~hi_q;
							if (!hi_q) begin
								ptr_q <= ptr_next; // R9
							end
							ret_q <= D_WDAT;
						end
					end
				end
				D_ACK: begin
					if (scl_fall) begin
						st_q  <= ret_q;
						cnt_q <= 4'h0;
						oe_q  <= 1'h0;
						if (ret_q == D_TX) begin
							oe_q  <= ~tx_byte[7]; // R6
							sh_q  <= {tx_byte[6:0], 1'h1};
							cnt_q <= 4'h1;
						end
					end
				end
				D_TX: begin
					if (scl_fall) begin
						if (byte_done) begin
							oe_q   <= 1'h0;
							st_q   <= D_MACK;
							sent_q <= 1'h1;
						end else begin
							oe_q  <= ~sh_q[7];
							sh_q  <= {sh_q[6:0], 1'h1};
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				D_MACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							st_q <= D_IDLE; // R11 R1
						end else begin
							st_q  <= D_ACK;
							ret_q <= D_TX;
							hi_q  <= ~hi_q; // R12
							if (!hi_q) begin
								ptr_q <= ptr_next; // R6 R9
							end
						end
					end
				end
				default: begin
					st_q <= D_IDLE;
					oe_q <= 1'h0;
				end
				endcase
			end
		end
	end
endmodule : gdrp_dev

// *** logic/gdrp_consts.svh ***
// constants shared by both ends of the gamma dac read path
`ifndef GDRP_CONSTS_SVH
`define GDRP_CONSTS_SVH

// seven-bit slave address; the value is an arbitrary choice
`define GDRP_ADDR      7'h2c
`define GDRP_DIR_WR    1'h0
`define GDRP_DIR_RD    1'h1
`define GDRP_NREG      5'h18
`define GDRP_BANK_LEN  8'h0c
`define GDRP_BANK2     8'h10
`define GDRP_HOLE_LEN  8'h04
`define GDRP_PTR_LAST  8'h1b
`define GDRP_BYTE_BITS 4'h8
`define GDRP_MODE_BIT  4'ha
`define GDRP_CLK_NS    16'h0005
`define GDRP_QTR_NS    16'h0271
`define GDRP_QTR_CYC   ((`GDRP_QTR_NS + `GDRP_CLK_NS - 16'h0001) / `GDRP_CLK_NS)

`endif

// *** logic/gdrp_pkg.sv ***
// types shared by both ends of the gamma dac read path
package gdrp_pkg;
	typedef logic [7:0]  gdrp_byte_t;
	typedef logic [4:0]  gdrp_idx_t;
	typedef logic [9:0]  gdrp_code_t;
	typedef logic [10:0] gdrp_word_t;

	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_ADDR = 3'h1,
		D_PTR  = 3'h2,
		D_WDAT = 3'h3,
		D_ACK  = 3'h4,
		D_TX   = 3'h5,
		D_MACK = 3'h6
	} gdrp_dst_t;

	typedef enum logic [2:0] {
		H_IDLE   = 3'h0,
		H_START  = 3'h1,
		H_LOAD   = 3'h2,
		H_BIT    = 3'h3,
		H_RSTART = 3'h4,
		H_STOP   = 3'h5
	} gdrp_hst_t;

	typedef enum logic [1:0] {
		SQ_ADDR_W = 2'h0,
		SQ_PTR    = 2'h1,
		SQ_ADDR_R = 2'h2,
		SQ_DATA   = 2'h3
	} gdrp_seq_t;
endpackage : gdrp_pkg

// *** logic/gdrp_if.sv ***
// two-wire link between the bus master and the gamma dac slave
`timescale 1ns/100ps
interface gdrp_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// open drain: any enabled driver pulls, otherwise the pull-up wins
	assign sda = (host_sda_oe ? host_sda_o : 1'h1) & (dev_sda_oe ? dev_sda_o : 1'h1);

	modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
	modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : gdrp_if

// *** logic/gdrp_host.sv ***
// master end: sets the pointer and reads a run of register bytes
`timescale 1ns/100ps
`include "gdrp_consts.svh"

module gdrp_host (
	input  wire logic               sys_clk,
	input  wire logic               srst,
	gdrp_if.host                    bus,
	input  wire logic               go,
	input  wire gdrp_pkg::gdrp_byte_t go_ptr,
	input  wire gdrp_pkg::gdrp_byte_t go_len,
	output logic                    busy,
	output logic                    rd_valid,
	output gdrp_pkg::gdrp_byte_t    rd_data,
	output logic                    done,
	output logic                    err
);
	import gdrp_pkg::*;

	localparam logic [7:0] QTR_LAST = 8'(`GDRP_QTR_CYC - 16'h0001);

	logic [1:0]  sda_sync_q;
	gdrp_hst_t   st_q;
	gdrp_seq_t   seq_q;
	logic [1:0]  ph_q;
	logic [7:0]  div_q;
	logic [3:0]  bit_q;
	logic [8:0]  out_q;
	logic [8:0]  in_q;
	gdrp_byte_t  ptr_q;
	gdrp_byte_t  left_q;
	gdrp_byte_t  data_q;
	logic        scl_q;
	logic        oe_q;
	logic        valid_q;
	logic        done_q;
	logic        err_q;

	wire         sda_s;
	wire         tick;
	wire         last_byte;
	wire [8:0]   frame_out;

	assign sda_s     = sda_sync_q[1];
	assign tick      = div_q == QTR_LAST;
	assign last_byte = left_q <= 8'h01;
	// ack slot of each frame: released for the slave and on the last read, driven low on other reads
	assign frame_out = (seq_q == SQ_ADDR_W) ? {`GDRP_ADDR, `GDRP_DIR_WR, 1'h1} // R2
	                 : (seq_q == SQ_PTR)    ? {ptr_q, 1'h1} // R4
	                 : (seq_q == SQ_ADDR_R) ? {`GDRP_ADDR, `GDRP_DIR_RD, 1'h1} // R5
	                 : {8'hff, last_byte}; // R1 R7 R8

	assign bus.scl         = scl_q;
	assign bus.host_sda_o  = 1'h0;
	assign bus.host_sda_oe = oe_q;
	assign busy            = st_q != H_IDLE;
	assign rd_valid        = valid_q;
	assign rd_data         = data_q;
	assign done            = done_q;
	assign err             = err_q;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sda_sync_q <= 2'h3;
		end else begin
			sda_sync_q <= {sda_sync_q[0], bus.sda};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q    <= H_IDLE;
			seq_q   <= SQ_ADDR_W;
			ph_q    <= 2'h0;
			div_q   <= 8'h00;
			bit_q   <= 4'h0;
			out_q   <= 9'h1ff;
			in_q    <= 9'h000;
			ptr_q   <= 8'h00;
			left_q  <= 8'h00;
			data_q  <= 8'h00;
			scl_q   <= 1'h1;
			oe_q    <= 1'h0;
			valid_q <= 1'h0;
			done_q  <= 1'h0;
			err_q   <= 1'h0;
		end else begin
			valid_q <= 1'h0;
			done_q  <= 1'h0;
			div_q   <= tick ? 8'h00 : div_q + 8'h01;
			if (st_q == H_IDLE) begin
				div_q <= 8'h00;
				if (go) begin
					st_q   <= H_START;
					seq_q  <= SQ_ADDR_W;
					ph_q   <= 2'h0;
					ptr_q  <= go_ptr;
					left_q <= go_len;
					err_q  <= 1'h0;
				end
			end else if (tick) begin
				ph_q <= ph_q + 2'h1;
				unique case (st_q)
				H_START: begin
					if (ph_q == 2'h0) begin
						oe_q <= 1'h1;
					end else begin
						scl_q <= 1'h0;
						st_q  <= H_LOAD;
					end
				end
				H_LOAD: begin
					oe_q  <= ~frame_out[8];
					out_q <= frame_out;
					bit_q <= 4'h0;
					ph_q  <= 2'h0;
					st_q  <= H_BIT;
				end
				H_BIT: begin
					if (ph_q == 2'h0) begin
						scl_q <= 1'h1;
					end else if (ph_q == 2'h1) begin
						in_q <= {in_q[7:0], sda_s};
					end else if (ph_q == 2'h2) begin
						scl_q <= 1'h0;
					end else if (bit_q != `GDRP_BYTE_BITS) begin
						oe_q  <= ~out_q[7];
						out_q <= {out_q[7:0], 1'h1};
						bit_q <= bit_q + 4'h1;
					end else if (seq_q == SQ_DATA) begin
						data_q  <= in_q[8:1];
						valid_q <= 1'h1;
						left_q  <= left_q - 8'h01;
						st_q    <= last_byte ? H_STOP : H_LOAD; // R8
					end else if (in_q[0]) begin
						err_q <= 1'h1;
						st_q  <= H_STOP;
					end else if (seq_q == SQ_PTR) begin
						seq_q <= SQ_ADDR_R;
						st_q  <= H_RSTART;
					end else begin
						seq_q <= (seq_q == SQ_ADDR_W) ? SQ_PTR : SQ_DATA;
						st_q  <= H_LOAD;
					end
				end
				H_RSTART: begin
					if (ph_q == 2'h0) begin
						oe_q <= 1'h0;
					end else if (ph_q == 2'h1) begin
						scl_q <= 1'h1;
					end else if (ph_q == 2'h2) begin
						oe_q <= 1'h1; // R5
					end else begin
						scl_q <= 1'h0;
						st_q  <= H_LOAD;
					end
				end
				H_STOP: begin
					if (ph_q == 2'h0) begin
						oe_q <= 1'h1;
					end else if (ph_q == 2'h1) begin
						scl_q <= 1'h1;
					end else if (ph_q == 2'h2) begin
						oe_q <= 1'h0; // R8
					end else begin
						st_q   <= H_IDLE;
						done_q <= 1'h1;
					end
				end
				default: begin
					st_q  <= H_IDLE;
					scl_q <= 1'h1;
					oe_q  <= 1'h0;
				end
				endcase
			end
		end
	end
endmodule : gdrp_host

// *** tb/gdrp_asserts.sv ***
// concurrent checks on the two-wire link between host and device
`timescale 1ns/100ps
module gdrp_asserts (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic sda
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// reset is the antecedent, so no default disable here
	property p_rst_idle;
		@(posedge sys_clk) disable iff (1'b0) srst |=> scl && !host_sda_oe && !dev_sda_oe;
	endproperty
	property p_host_low;
		host_sda_oe |-> !host_sda_o && !sda;
	endproperty
	property p_dev_low;
		dev_sda_oe |-> !dev_sda_o && !sda;
	endproperty
	// device only moves data while the clock is low
	property p_dev_edge;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	property p_dev_hold;
		$rose(dev_sda_oe) |=> dev_sda_oe [*8];
	endproperty
	property p_scl_high;
		$rose(scl) |=> scl [*8];
	endproperty
	property p_scl_low;
		$fell(scl) |=> !scl [*8];
	endproperty
	property p_scl_back;
		$fell(scl) |-> ##[1:1000] $rose(scl);
	endproperty

	a_rst_idle:  assert property (p_rst_idle) else $error("link not idle after reset");
	a_host_low:  assert property (p_host_low) else $error("host drive not low");
	a_dev_low:   assert property (p_dev_low) else $error("device drive not low");
	a_dev_edge:  assert property (p_dev_edge) else $error("device data moved with clock high");
	a_dev_hold:  assert property (p_dev_hold) else $error("device bit too short");
	a_scl_high:  assert property (p_scl_high) else $error("clock high too short");
	a_scl_low:   assert property (p_scl_low) else $error("clock low too short");
	a_scl_back:  assert property (p_scl_back) else $error("clock stuck low");

	c_dev_drive: cover property ($rose(dev_sda_oe));
	c_start:     cover property (scl && $fell(sda));
	c_stop:      cover property (scl && $rose(sda));
endmodule : gdrp_asserts

// *** tb/gdrp_dac_i2c_read_path_test.sv ***
// reads register runs through the master end and checks every byte
`timescale 1ns/100ps
module gamma_dac_i2c_read_path_test;
	import gdrp_pkg::*;
	logic       sys_clk;
	logic       srst;
	logic       ld_en;
	gdrp_idx_t  ld_idx;
	logic       ld_mode;
	gdrp_code_t ld_code;
	logic       go;
	gdrp_byte_t go_ptr;
	gdrp_byte_t go_len;
	logic       busy;
	logic       rd_valid;
	gdrp_byte_t rd_data;
	logic       done;
	logic       err;
	logic       active;
	logic       byte_sent;
	gdrp_byte_t dptr;
	int         bad_count = 0;
	int         n_checks = 0;

	gdrp_if lnk ();

	gdrp_dev u_gdrp_dev (.sys_clk(sys_clk), .srst(srst), .bus(lnk), .ld_en(ld_en),
		.ld_idx(ld_idx), .ld_mode(ld_mode), .ld_code(ld_code), .ptr(dptr), .active(active),
		.byte_sent(byte_sent));
	gdrp_host u_gdrp_host (.sys_clk(sys_clk), .srst(srst), .bus(lnk), .go(go),
		.go_ptr(go_ptr), .go_len(go_len), .busy(busy), .rd_valid(rd_valid),
		.rd_data(rd_data), .done(done), .err(err));
	gdrp_asserts u_gdrp_asserts (.sys_clk(sys_clk), .srst(srst), .scl(lnk.scl),
		.host_sda_o(lnk.host_sda_o), .host_sda_oe(lnk.host_sda_oe),
		.dev_sda_o(lnk.dev_sda_o), .dev_sda_oe(lnk.dev_sda_oe), .sda(lnk.sda));

	initial begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic print_verdict();
		if (bad_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk

	// hole pointers read as zero; bank two sits four slots up
	function automatic gdrp_byte_t ev(input gdrp_byte_t p, input logic hi);
		gdrp_idx_t  i;
		gdrp_code_t c;
		i = (p < 8'h0c) ? p[4:0] : p[4:0] - 5'h04;
		c = 10'h3ff ^ {i, i};
		if (p >= 8'h0c && p <= 8'h0f)
			return 8'h00;
		return hi ? {i[0], 5'h00, c[9:8]} : c[7:0];
	endfunction : ev

	task automatic rd(input gdrp_byte_t p0, input gdrp_byte_t n, input gdrp_byte_t pe);
		gdrp_byte_t p;
		logic       hi;
		gdrp_byte_t k;
		int         t;
		gdrp_byte_t s;
		p = p0;
		hi = 1'h1;
		k = 8'h00;
		t = 0;
		s = 8'h00;
		@(posedge sys_clk);
		go <= 1'h1;
		go_ptr <= p0;
		go_len <= n;
		@(posedge sys_clk);
		go <= 1'h0;
		while (done !== 1'h1 && t < 75000) begin
			@(posedge sys_clk);
			#1;
			t++;
			if (byte_sent === 1'h1)
				s++;
			if (rd_valid === 1'h1) begin
				chk(rd_data, ev(p, hi));
				if (!hi)
					p = (p == 8'h1b) ? 8'h00 : p + 8'h01;
				hi = !hi;
				k++;
			end
		end
		if (t >= 75000) begin
			bad_count++;
			print_verdict();
		end
		chk(k, n);
		chk(s, n);
		chk(dptr, pe);
		@(posedge sys_clk);
		#1;
		chk({6'h00, err, active}, 8'h00);
		chk({6'h00, lnk.scl, lnk.sda}, 8'h03);
	endtask : rd

	initial begin
		srst = 1'h1;
		go = 1'h0;
		go_ptr = 8'h00;
		go_len = 8'h00;
		ld_en = 1'h0;
		ld_idx = 5'h00;
		ld_mode = 1'h0;
		ld_code = 10'h000;
		repeat (6) @(posedge sys_clk);
		srst <= 1'h0;
		for (int i = 0; i < 24; i++) begin
			@(posedge sys_clk);
			ld_en <= 1'h1;
			ld_idx <= i[4:0];
			ld_mode <= i[0];
			ld_code <= 10'h3ff ^ {i[4:0], i[4:0]};
		end
		@(posedge sys_clk);
		ld_en <= 1'h0;
		// across the hole into bank two
		rd(8'h0b, 8'h0c, 8'h10);
		// wrap to zero, odd count
		rd(8'h1b, 8'h03, 8'h00);
		print_verdict();
	end
endmodule : gamma_dac_i2c_read_path_test
